// ---- abd_decoder.sv ----
/*
  Opcode decoder and sequencer for the arithmetic, logic and boolean
  groups: takes opcode and operand bytes, counts execution cycles and
  returns the result, flag updates and write strobes.
  Assumes program memory and datapath share clk; the datapath presents
  the operand selected by decOut/addrOut from the cycle after the take.
*/
`timescale 1ns/1ps
`default_nettype none

module abd_decoder
  import abd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       codeValid,
  input  wire logic [7:0] codeByte,
  output logic            codeReady,
  input  wire logic [7:0] accIn,
  input  wire logic [7:0] opndIn,
  input  wire logic       bitIn,
  input  wire abd_flags_s flagsIn,
  output abd_dec_s        decOut,
  output logic [7:0]      addrOut,
  output logic            busy,
  output logic            done,
  output abd_res_s        resOut
);

  ////////////////////////////////////////////////////////////////////
  function automatic abd_dec_s abdDecode(input logic [7:0] opc);
    abd_dec_s   d;
    logic [3:0] hi;
    logic [3:0] lo;
    logic       isLogic;
    d        = '0;
    hi       = opc[7:4];
    lo       = opc[3:0];
    isLogic  = 1'b0;
    d.op     = OP_NONE;
    d.src    = SRC_NONE;
    d.dst    = DST_ACC;
    d.regIdx = opc[2:0];
    d.ptrSel = opc[0];
    d.len    = LEN_TWO;
    d.cyc    = CYC_TWO;
    d.legal  = 1'b1;
    if (opc == OPC_SWAP_NIBBLES) begin
      d.op = OP_SWAP_NIBBLES;
      d.len = LEN_ONE;
      d.cyc = CYC_ONE;
    end else if (opc == OPC_ROTATE_LEFT_CARRY) begin
      d.op = OP_ROTATE_LEFT_CARRY;
      d.len = LEN_ONE;
      d.cyc = CYC_ONE;
    end else if (opc == OPC_ROTATE_RIGHT_CARRY) begin
      d.op = OP_ROTATE_RIGHT_CARRY;
      d.len = LEN_ONE;
      d.cyc = CYC_ONE;
    end else if (opc == OPC_CARRY_AND_BIT) begin
      d.op = OP_CARRY_AND_BIT;
    end else if (opc == OPC_CARRY_AND_NBIT) begin
      d.op = OP_CARRY_AND_NBIT;
    end else if (opc == OPC_CARRY_OR_BIT) begin
      d.op = OP_CARRY_OR_BIT;
    end else if (opc == OPC_CARRY_OR_NBIT) begin
      d.op = OP_CARRY_OR_NBIT;
    end else if (opc == OPC_BIT_TO_CARRY) begin
      d.op = OP_BIT_TO_CARRY;
    end else if (opc == OPC_CARRY_TO_BIT) begin
      d.op = OP_CARRY_TO_BIT;
      d.cyc = CYC_THREE;
    end else begin
      case (hi)
        HI_ADD:                  d.op = OP_ADD;
        HI_ADD_WITH_CARRY:       d.op = OP_ADD_WITH_CARRY;
        HI_SUBTRACT_WITH_BORROW: d.op = OP_SUBTRACT_WITH_BORROW;
        HI_LOGICAL_AND:          d.op = OP_LOGICAL_AND;
        HI_LOGICAL_OR:           d.op = OP_LOGICAL_OR;
        HI_LOGICAL_XOR:          d.op = OP_LOGICAL_XOR;
        default:                 d.legal = 1'b0;
      endcase
      isLogic = (hi == HI_LOGICAL_AND) || (hi == HI_LOGICAL_OR) ||
                (hi == HI_LOGICAL_XOR);
      if (lo[3]) begin
        d.src = SRC_REG;
        d.len = LEN_ONE;
        d.cyc = CYC_ONE;
      end else if (lo[3:1] == LO_IND) begin
        d.src = SRC_INDIRECT;
        d.len = LEN_ONE;
      end else if (lo == LO_IMM) begin
        d.src = SRC_IMM;
      end else if (lo == LO_DIR) begin
        d.src = SRC_DIRECT;
      end else if (isLogic && lo == LO_DIR_ACC) begin
        d.src = SRC_ACC;
        d.dst = DST_DIRECT;
        d.cyc = CYC_THREE;
      end else if (isLogic && lo == LO_DIR_IMM) begin
        d.src = SRC_IMM;
        d.dst = DST_DIRECT;
        d.len = LEN_THREE;
        d.cyc = CYC_THREE;
      end else begin
        d.legal = 1'b0;
      end
    end
    if (d.op >= OP_CARRY_AND_BIT) begin
      d.src = (d.op == OP_CARRY_TO_BIT) ? SRC_CARRY : SRC_BIT;
      d.dst = (d.op == OP_CARRY_TO_BIT) ? DST_BIT : DST_CARRY;
    end
    // Unknown codes retire as one-byte no-ops with no write strobes
    if (!d.legal) begin
      d.op  = OP_NONE;
      d.src = SRC_NONE;
      d.dst = DST_NONE;
      d.len = LEN_ONE;
      d.cyc = CYC_ONE;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////
  function automatic abd_res_s abdExec(
    input abd_dec_s   d,
    input logic [7:0] acc,
    input logic [7:0] opnd,
    input logic [7:0] imm,
    input abd_flags_s f,
    input logic       bitv
  );
    abd_res_s   r;
    logic [7:0] x;
    logic [7:0] y;
    logic [8:0] wide;
    logic [4:0] nib;
    logic       cin;
    r       = '0;
    r.flags = f;
    x       = (d.dst == DST_DIRECT) ? opnd : acc;
    y       = (d.src == SRC_IMM) ? imm : (d.src == SRC_ACC) ? acc : opnd;
    cin     = (d.op == OP_ADD) ? 1'b0 : f.cy;
    wide    = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    nib     = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    case (d.op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        r.value   = wide[7:0];
        r.flags   = '{cy: wide[8], ac: nib[4],
                      ov: (x[7] == y[7]) && (wide[7] != x[7])};
        r.flagsWe = FLAGS_ARITH;
        r.accWe   = 1'b1;
      end
      OP_SUBTRACT_WITH_BORROW: begin
        wide      = {1'b0, x} - {1'b0, y} - {8'h00, cin};
        nib       = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
        r.value   = wide[7:0];
        r.flags   = '{cy: wide[8], ac: nib[4],
                      ov: (x[7] != y[7]) && (wide[7] != x[7])};
        r.flagsWe = FLAGS_ARITH;
        r.accWe   = 1'b1;
      end
      // Logic results leave every flag alone
      OP_LOGICAL_AND, OP_LOGICAL_OR, OP_LOGICAL_XOR: begin
        r.value = (d.op == OP_LOGICAL_AND) ? (x & y) :
                  (d.op == OP_LOGICAL_OR)  ? (x | y) : (x ^ y);
        r.accWe = (d.dst == DST_ACC);
        r.dirWe = (d.dst == DST_DIRECT);
      end
      OP_SWAP_NIBBLES: begin
        r.value = {acc[3:0], acc[7:4]};
        r.accWe = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY: begin
        r.value    = {acc[6:0], f.cy};
        r.flags.cy = acc[7];
        r.flagsWe  = FLAGS_CY;
        r.accWe    = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY: begin
        r.value    = {f.cy, acc[7:1]};
        r.flags.cy = acc[0];
        r.flagsWe  = FLAGS_CY;
        r.accWe    = 1'b1;
      end
      OP_CARRY_AND_BIT, OP_CARRY_AND_NBIT, OP_CARRY_OR_BIT,
      OP_CARRY_OR_NBIT, OP_BIT_TO_CARRY: begin
        case (d.op)
          OP_CARRY_AND_BIT:  r.flags.cy = f.cy & bitv;
          OP_CARRY_AND_NBIT: r.flags.cy = f.cy & ~bitv;
          OP_CARRY_OR_BIT:   r.flags.cy = f.cy | bitv;
          OP_CARRY_OR_NBIT:  r.flags.cy = f.cy | ~bitv;
          default:           r.flags.cy = bitv;
        endcase
        r.flagsWe = FLAGS_CY;
      end
      OP_CARRY_TO_BIT: begin
        r.bitVal = f.cy;
        r.bitWe  = 1'b1;
      end
      default: r = r;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  abd_st_s  st_reg;
  abd_st_s  st_next;
  abd_dec_s newDec;
  logic     completing;
  logic     takeOpcode;
  logic     takeByte;
  logic [7:0] immByte;

  assign newDec     = abdDecode(codeByte);
  assign completing = (st_reg.state == S_WAIT) &&
                      (st_reg.bytesLeft == '0) && (st_reg.cnt == '0);
  // A new opcode may enter in the same cycle the previous one retires
  assign takeOpcode = codeValid && st_reg.codeReady &&
                      ((st_reg.state == S_IDLE) || completing);
  assign takeByte   = codeValid && st_reg.codeReady &&
                      (st_reg.state == S_WAIT) && (st_reg.bytesLeft != '0);
  assign immByte    = (st_reg.dec.len == LEN_THREE) ? st_reg.b3 : st_reg.b2;

  always_comb begin
    st_next               = st_reg;
    st_next.done          = 1'b0;
    st_next.res.flagsWe   = '0;
    st_next.res.accWe     = 1'b0;
    st_next.res.dirWe     = 1'b0;
    st_next.res.bitWe     = 1'b0;
    if (st_reg.state == S_WAIT) begin
      if (takeByte) begin
        if (st_reg.bytesLeft == st_reg.dec.len - LEN_ONE) begin
          st_next.b2 = codeByte;
        end else begin
          st_next.b3 = codeByte;
        end
        st_next.bytesLeft = st_reg.bytesLeft - LEN_ONE;
      end
      if (st_reg.cnt != '0) begin
        st_next.cnt = st_reg.cnt - CYC_ONE;
      end
      if (completing) begin
        st_next.res   = abdExec(st_reg.dec, accIn, opndIn, immByte,
                                flagsIn, bitIn);
        st_next.done  = 1'b1;
        st_next.state = S_IDLE;
      end
    end
    if (takeOpcode) begin
      st_next.state     = S_WAIT;
      st_next.dec       = newDec;
      st_next.bytesLeft = newDec.len - LEN_ONE;
      st_next.cnt       = newDec.cyc - CYC_ONE;
    end
    // Ready only when the next cycle can use a byte
    st_next.codeReady = (st_next.state == S_IDLE) ||
                        (st_next.bytesLeft != '0) || (st_next.cnt == '0);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign codeReady = st_reg.codeReady;
  assign decOut    = st_reg.dec;
  assign addrOut   = st_reg.b2;
  assign busy      = (st_reg.state == S_WAIT);
  assign done      = st_reg.done;
  assign resOut    = st_reg.res;

  ////////////////////////////////////////////////////////////////////
  chk_add_reg_decode: assert property (
    @(posedge clk) disable iff (!arst_n)
    takeOpcode && codeByte[7:3] == 5'h05 |=>
      decOut.op == OP_ADD && decOut.src == SRC_REG &&
      decOut.len == LEN_ONE && decOut.regIdx == $past(codeByte[2:0]))
    else $error("add register opcode decoded wrongly");

  chk_one_cycle_done: assert property (
    @(posedge clk) disable iff (!arst_n)
    takeOpcode && newDec.cyc == CYC_ONE |-> ##2 done)
    else $error("single cycle instruction did not retire in time");

  chk_direct_two_cyc: assert property (
    @(posedge clk) disable iff (!arst_n)
    takeOpcode && codeByte == 8'h25 ##1 codeValid |=> !done ##1 done)
    else $error("direct add did not take two cycles");

  chk_rmw_three_cyc: assert property (
    @(posedge clk) disable iff (!arst_n)
    takeOpcode && (codeByte == 8'h52 || codeByte == 8'h62) ##1 codeValid
      |=> !done ##1 !done ##1 done && resOut.dirWe && !resOut.accWe)
    else $error("direct logic write timing wrong");

  chk_indirect_ptr: assert property (
    @(posedge clk) disable iff (!arst_n)
    takeOpcode && codeByte[7:1] == 7'h13 |=>
      decOut.src == SRC_INDIRECT && decOut.ptrSel == $past(codeByte[0])
      && decOut.cyc == CYC_TWO)
    else $error("indirect pointer select wrong");

  chk_arith_flags: assert property (
    @(posedge clk) disable iff (!arst_n)
    completing && decOut.op inside {OP_ADD, OP_ADD_WITH_CARRY,
      OP_SUBTRACT_WITH_BORROW} |=> resOut.flagsWe == FLAGS_ARITH)
    else $error("arithmetic did not update flags");

  chk_logic_flags: assert property (
    @(posedge clk) disable iff (!arst_n)
    completing && decOut.op inside {OP_LOGICAL_AND, OP_LOGICAL_OR,
      OP_LOGICAL_XOR, OP_SWAP_NIBBLES} |=> resOut.flagsWe == '0)
    else $error("logic operation touched flags");

  chk_swap_value: assert property (
    @(posedge clk) disable iff (!arst_n)
    completing && decOut.op == OP_SWAP_NIBBLES |=>
      resOut.value == {$past(accIn[3:0]), $past(accIn[7:4])})
    else $error("nibble swap result wrong");

  chk_rotate_left: assert property (
    @(posedge clk) disable iff (!arst_n)
    completing && decOut.op == OP_ROTATE_LEFT_CARRY |=>
      {resOut.flags.cy, resOut.value} ==
      {$past(accIn), $past(flagsIn.cy)})
    else $error("rotate through carry wrong");

  chk_subtract_reg: assert property (
    @(posedge clk) disable iff (!arst_n)
    completing && decOut.op == OP_SUBTRACT_WITH_BORROW &&
      decOut.src == SRC_REG |=> resOut.value == 8'($past(accIn) -
      $past(opndIn) - {7'h00, $past(flagsIn.cy)}))
    else $error("subtract with borrow result wrong");

  chk_carry_to_bit: assert property (
    @(posedge clk) disable iff (!arst_n)
    completing && decOut.op == OP_CARRY_TO_BIT |=>
      resOut.bitWe && resOut.bitVal == $past(flagsIn.cy))
    else $error("carry to bit copy wrong");

endmodule

`default_nettype wire

// ---- abd_pkg.sv ----
/*
  Constants, types and state layout for the opcode decoder of the
  arithmetic, logic and boolean instruction groups.
  Assumes one clock domain; opcode bytes arrive from program memory.
*/
// How it works
// - Add register: 28-2F, one byte, one cycle
// - Add direct byte 25: two bytes, two cycles
// - Add indirect 26-27, pointer by bit zero
// - Add immediate 24: two bytes, two cycles
// - Add register with carry 38-3F, single cycle
// - Add immediate with carry 34: two cycles
// - Subtract register with borrow 98-9F, single cycle
// - Subtract immediate with borrow 94, two cycles
// - 52: AND accumulator into direct, three cycles
// - 53: AND immediate into direct, three bytes
// - OR register into accumulator 48-4F, single cycle
// - 62: XOR accumulator into direct, three cycles
// - 63: XOR immediate into direct, three bytes
// - C4: swap accumulator nibbles, single cycle
// - 33: rotate accumulator and carry left
// - 13: rotate accumulator and carry right
// - 82: AND addressed bit into carry
// - B0: AND inverted bit into carry
// - 72/A0: OR bit or inverse into carry
// - A2: copy addressed bit into carry
// - 92: copy carry to bit, three cycles
package abd_pkg;

  localparam logic [3:0] HI_ADD                  = 4'h2;
  localparam logic [3:0] HI_ADD_WITH_CARRY       = 4'h3;
  localparam logic [3:0] HI_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] HI_LOGICAL_OR           = 4'h4;
  localparam logic [3:0] HI_LOGICAL_AND          = 4'h5;
  localparam logic [3:0] HI_LOGICAL_XOR          = 4'h6;
  localparam logic [3:0] LO_DIR_ACC              = 4'h2;
  localparam logic [3:0] LO_DIR_IMM              = 4'h3;
  localparam logic [3:0] LO_IMM                  = 4'h4;
  localparam logic [3:0] LO_DIR                  = 4'h5;
  localparam logic [2:0] LO_IND                  = 3'h3;

  localparam logic [7:0] OPC_SWAP_NIBBLES       = 8'hC4;
  localparam logic [7:0] OPC_ROTATE_LEFT_CARRY  = 8'h33;
  localparam logic [7:0] OPC_ROTATE_RIGHT_CARRY = 8'h13;
  localparam logic [7:0] OPC_CARRY_AND_BIT      = 8'h82;
  localparam logic [7:0] OPC_CARRY_AND_NBIT     = 8'hB0;
  localparam logic [7:0] OPC_CARRY_OR_BIT       = 8'h72;
  localparam logic [7:0] OPC_CARRY_OR_NBIT      = 8'hA0;
  localparam logic [7:0] OPC_BIT_TO_CARRY       = 8'hA2;
  localparam logic [7:0] OPC_CARRY_TO_BIT       = 8'h92;

  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic { S_IDLE = 1'b0, S_WAIT = 1'b1 } abd_state_e;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000, OP_ADD = 4'b0001, OP_ADD_WITH_CARRY = 4'b0010,
    OP_SUBTRACT_WITH_BORROW = 4'b0011, OP_LOGICAL_AND = 4'b0100,
    OP_LOGICAL_OR = 4'b0101, OP_LOGICAL_XOR = 4'b0110,
    OP_SWAP_NIBBLES = 4'b0111, OP_ROTATE_LEFT_CARRY = 4'b1000,
    OP_ROTATE_RIGHT_CARRY = 4'b1001, OP_CARRY_AND_BIT = 4'b1010,
    OP_CARRY_AND_NBIT = 4'b1011, OP_CARRY_OR_BIT = 4'b1100,
    OP_CARRY_OR_NBIT = 4'b1101, OP_BIT_TO_CARRY = 4'b1110,
    OP_CARRY_TO_BIT = 4'b1111
  } abd_op_e;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_REG = 3'b001, SRC_DIRECT = 3'b010,
    SRC_INDIRECT = 3'b011, SRC_IMM = 3'b100, SRC_BIT = 3'b101,
    SRC_CARRY = 3'b110, SRC_ACC = 3'b111
  } abd_src_e;

  typedef enum logic [2:0] {
    DST_NONE = 3'b000, DST_ACC = 3'b001, DST_DIRECT = 3'b010,
    DST_CARRY = 3'b011, DST_BIT = 3'b100
  } abd_dst_e;

  typedef struct packed { logic cy; logic ac; logic ov; } abd_flags_s;

  localparam abd_flags_s FLAGS_ARITH = 3'h7;
  localparam abd_flags_s FLAGS_CY    = 3'h4;

  typedef struct packed {
    abd_op_e op; abd_src_e src; abd_dst_e dst; logic [2:0] regIdx;
    logic ptrSel; logic [1:0] len; logic [1:0] cyc; logic legal;
  } abd_dec_s;

  typedef struct packed {
    logic [7:0] value; logic bitVal; abd_flags_s flags;
    abd_flags_s flagsWe; logic accWe; logic dirWe; logic bitWe;
  } abd_res_s;

  typedef struct packed {
    abd_state_e state; abd_dec_s dec; logic [1:0] bytesLeft;
    logic [1:0] cnt; logic [7:0] b2; logic [7:0] b3;
    logic codeReady; logic done; abd_res_s res;
  } abd_st_s;

endpackage

// ---- abd_prog_mem.sv ----
/*
  Program memory model for the decoder's instruction port.
  Assumes the bench queues bytes at rising edges and sets slow steady.
*/
`timescale 1ns/1ps
`default_nettype none

module abd_prog_mem (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       codeReady,
  input  wire logic       slow,
  output logic            codeValid,
  output logic [7:0]      codeByte,
  output logic            tookByte
);
  logic [7:0] q[$];
  logic       validQ = 1'b0;
  logic [7:0] byteQ  = 8'hA5;

  assign codeValid = validQ;
  assign codeByte  = byteQ;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  ////////////////////////////////////////
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tookByte <= 1'b0;
    end else begin
      tookByte <= validQ && codeReady;
    end
  end

  // Byte held until taken; idle line toggles so no stale value passes
  always @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q.delete();
      validQ <= 1'b0;
      byteQ  <= 8'hA5;
    end else begin
      if (tookByte) begin
        void'(q.pop_front());
      end
      if (q.size() > 0 && !(slow && tookByte)) begin
        validQ <= 1'b1;
        byteQ  <= q[0];
      end else begin
        validQ <= 1'b0;
        byteQ  <= ~byteQ;
      end
    end
  end
endmodule

`default_nettype wire

// ---- tb_alu_bool_instr_decoder.sv ----
/*
  Self-checking bench for the opcode decoder, one task per scenario.
  Assumes abd_prog_mem feeds opcodes; the bench plays the datapath.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_alu_bool_instr_decoder
  import abd_pkg::*;
;
  logic       clk     = 1'b0;
  logic       arst_n  = 1'b0;
  logic       slow    = 1'b0;
  logic [7:0] accIn;
  logic [7:0] opndIn;
  logic       bitIn;
  abd_flags_s flagsIn;
  logic       codeValid;
  logic       codeReady;
  logic       tookByte;
  logic       busy;
  logic       done;
  logic [7:0] codeByte;
  logic [7:0] addrOut;
  abd_dec_s   decOut;
  abd_res_s   resOut;
  int         errorCnt = 0;
  int         checked  = 0;
  int         cycCnt   = 0;

  always #50 clk = ~clk;
  always @(posedge clk) cycCnt <= cycCnt + 1;

  abd_decoder DUT (.clk(clk), .arst_n(arst_n), .codeValid(codeValid),
    .codeByte(codeByte), .codeReady(codeReady), .accIn(accIn),
    .opndIn(opndIn), .bitIn(bitIn), .flagsIn(flagsIn), .decOut(decOut),
    .addrOut(addrOut), .busy(busy), .done(done), .resOut(resOut));
  abd_prog_mem pm (.clk(clk), .arst_n(arst_n), .codeReady(codeReady),
    .slow(slow), .codeValid(codeValid), .codeByte(codeByte),
    .tookByte(tookByte));

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic abd_dec_s mk(input abd_op_e o, input abd_src_e s,
                                  input abd_dst_e d, input logic [1:0] l,
                                  input logic [1:0] c);
    mk = '{op: o, src: s, dst: d, regIdx: 3'h0, ptrSel: 1'b0, len: l,
           cyc: c, legal: 1'b1};
  endfunction

  function automatic abd_dec_s ref_dec(input logic [7:0] c);
    abd_dec_s d;
    casez (c)
      8'b0010_1???: d = mk(OP_ADD, SRC_REG, DST_ACC, 2'h1, 2'h1);
      8'h25: d = mk(OP_ADD, SRC_DIRECT, DST_ACC, 2'h2, 2'h2);
      8'b0010_011?: d = mk(OP_ADD, SRC_INDIRECT, DST_ACC, 2'h1, 2'h2);
      8'h24: d = mk(OP_ADD, SRC_IMM, DST_ACC, 2'h2, 2'h2);
      8'b0011_1???: d = mk(OP_ADD_WITH_CARRY, SRC_REG, DST_ACC, 2'h1, 2'h1);
      8'h34: d = mk(OP_ADD_WITH_CARRY, SRC_IMM, DST_ACC, 2'h2, 2'h2);
      8'b1001_1???: d = mk(OP_SUBTRACT_WITH_BORROW, SRC_REG, DST_ACC,
                           2'h1, 2'h1);
      8'h94: d = mk(OP_SUBTRACT_WITH_BORROW, SRC_IMM, DST_ACC, 2'h2, 2'h2);
      8'h52: d = mk(OP_LOGICAL_AND, SRC_ACC, DST_DIRECT, 2'h2, 2'h3);
      8'h53: d = mk(OP_LOGICAL_AND, SRC_IMM, DST_DIRECT, 2'h3, 2'h3);
      8'b0100_1???: d = mk(OP_LOGICAL_OR, SRC_REG, DST_ACC, 2'h1, 2'h1);
      8'h62: d = mk(OP_LOGICAL_XOR, SRC_ACC, DST_DIRECT, 2'h2, 2'h3);
      8'h63: d = mk(OP_LOGICAL_XOR, SRC_IMM, DST_DIRECT, 2'h3, 2'h3);
      8'hC4: d = mk(OP_SWAP_NIBBLES, SRC_ACC, DST_ACC, 2'h1, 2'h1);
      8'h33: d = mk(OP_ROTATE_LEFT_CARRY, SRC_ACC, DST_ACC, 2'h1, 2'h1);
      8'h13: d = mk(OP_ROTATE_RIGHT_CARRY, SRC_ACC, DST_ACC, 2'h1, 2'h1);
      8'h82: d = mk(OP_CARRY_AND_BIT, SRC_BIT, DST_CARRY, 2'h2, 2'h2);
      8'hB0: d = mk(OP_CARRY_AND_NBIT, SRC_BIT, DST_CARRY, 2'h2, 2'h2);
      8'h72: d = mk(OP_CARRY_OR_BIT, SRC_BIT, DST_CARRY, 2'h2, 2'h2);
      8'hA0: d = mk(OP_CARRY_OR_NBIT, SRC_BIT, DST_CARRY, 2'h2, 2'h2);
      8'hA2: d = mk(OP_BIT_TO_CARRY, SRC_BIT, DST_CARRY, 2'h2, 2'h2);
      8'h92: d = mk(OP_CARRY_TO_BIT, SRC_CARRY, DST_BIT, 2'h2, 2'h3);
      default: begin
        d = mk(OP_NONE, SRC_NONE, DST_NONE, 2'h1, 2'h1);
        d.legal = 1'b0;
      end
    endcase
    d.regIdx = c[2:0];
    d.ptrSel = c[0];
    return d;
  endfunction

  // Uses the bench's datapath inputs, not the design's
  function automatic abd_res_s ref_res(input abd_dec_s d,
                                       input logic [7:0] im);
    abd_res_s   r;
    logic [7:0] x;
    logic [7:0] y;
    logic [8:0] s;
    logic [4:0] h;
    logic       ci;
    r = '0;
    h = 5'h00;
    x = (d.dst == DST_DIRECT) ? opndIn : accIn;
    y = (d.src == SRC_IMM) ? im : (d.src == SRC_ACC) ? accIn : opndIn;
    ci = (d.op == OP_ADD) ? 1'b0 : flagsIn.cy;
    case (d.op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        s = x + y + ci;
        h = x[3:0] + y[3:0] + ci;
        r.flags.ov = (x[7] == y[7]) && (s[7] != x[7]);
      end
      OP_SUBTRACT_WITH_BORROW: begin
        s = x - y - ci;
        h = x[3:0] - y[3:0] - ci;
        r.flags.ov = (x[7] != y[7]) && (s[7] != x[7]);
      end
      OP_LOGICAL_AND: s = {1'b0, x & y};
      OP_LOGICAL_OR: s = {1'b0, x | y};
      OP_LOGICAL_XOR: s = {1'b0, x ^ y};
      OP_SWAP_NIBBLES: s = {1'b0, accIn[3:0], accIn[7:4]};
      OP_ROTATE_LEFT_CARRY: s = {accIn, flagsIn.cy};
      OP_ROTATE_RIGHT_CARRY: s = {accIn[0], flagsIn.cy, accIn[7:1]};
      OP_CARRY_AND_BIT: s = {flagsIn.cy & bitIn, 8'h00};
      OP_CARRY_AND_NBIT: s = {flagsIn.cy & ~bitIn, 8'h00};
      OP_CARRY_OR_BIT: s = {flagsIn.cy | bitIn, 8'h00};
      OP_CARRY_OR_NBIT: s = {flagsIn.cy | ~bitIn, 8'h00};
      OP_BIT_TO_CARRY: s = {bitIn, 8'h00};
      default: s = 9'h000;
    endcase
    r.value = s[7:0];
    r.flags.cy = s[8];
    r.flags.ac = h[4];
    r.bitVal = flagsIn.cy;
    r.bitWe = (d.op == OP_CARRY_TO_BIT);
    r.accWe = (d.dst == DST_ACC);
    r.dirWe = (d.dst == DST_DIRECT);
    if (d.op inside {[OP_ADD:OP_SUBTRACT_WITH_BORROW]}) begin
      r.flagsWe = FLAGS_ARITH;
    end else if (d.op inside {[OP_ROTATE_LEFT_CARRY:OP_BIT_TO_CARRY]}) begin
      r.flagsWe = FLAGS_CY;
    end
    return r;
  endfunction

  ////////////////////////////////////////
  task automatic setdp(input logic [7:0] a, input logic [7:0] o,
                       input logic b, input logic c);
    @(negedge clk);
    accIn = a;
    opndIn = o;
    bitIn = b;
    flagsIn = {c, 2'b01};
  endtask

  // One instruction from idle; slow mode spaces the bytes
  task automatic run(input logic [7:0] opc, input logic [7:0] b2 = 8'h00,
                     input logic [7:0] b3 = 8'h00);
    abd_dec_s e;
    abd_res_s r;
    int       t0 = -1;
    int       lat = -1;
    int       ln;
    e = ref_dec(opc);
    r = ref_res(e, (e.len == LEN_THREE) ? b3 : b2);
    ln = slow ? 2 * e.len - 1 : e.len;
    @(posedge clk);
    pm.push(opc);
    if (e.len != LEN_ONE) pm.push(b2);
    if (e.len == LEN_THREE) pm.push(b3);
    for (int n = 0; n < 20 && lat < 0; n++) begin
      @(negedge clk);
      if (t0 < 0 && tookByte === 1'b1) t0 = cycCnt;
      if (t0 >= 0 && done === 1'b1) lat = cycCnt - t0;
    end
    chk("latency", (ln > e.cyc) ? ln : e.cyc, lat);
    chk("op", e.op, decOut.op);
    chk("len", e.len, decOut.len);
    chk("cyc", e.cyc, decOut.cyc);
    chk("legal", e.legal, decOut.legal);
    if (e.op inside {[OP_ADD:OP_LOGICAL_XOR]}) begin
      chk("src", e.src, decOut.src);
      chk("dst", e.dst, decOut.dst);
    end
    if (e.src == SRC_REG) chk("regIdx", opc[2:0], decOut.regIdx);
    if (e.src == SRC_INDIRECT) chk("ptrSel", opc[0], decOut.ptrSel);
    if (e.len != LEN_ONE) chk("addrOut", b2, addrOut);
    chk("writes", {r.flagsWe, r.accWe, r.dirWe, r.bitWe},
        {resOut.flagsWe, resOut.accWe, resOut.dirWe, resOut.bitWe});
    if (r.accWe || r.dirWe) chk("value", r.value, resOut.value);
    chk("flags", r.flags & r.flagsWe, resOut.flags & r.flagsWe);
    if (r.bitWe) chk("bitVal", r.bitVal, resOut.bitVal);
    @(negedge clk);
    chk("donePulse", 1'b0, done);
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    setdp(8'h00, 8'h00, 1'b0, 1'b0);
    repeat (4) @(negedge clk);
    chk("rstReady", 1'b0, codeReady);
    chk("rstBusy", 1'b0, busy);
    chk("rstDone", 1'b0, done);
    chk("rstOp", OP_NONE, decOut.op);
    arst_n = 1'b1;
    @(negedge clk);
    chk("readyAfterRst", 1'b1, codeReady);
    $display("test reset done");
  endtask

  task automatic t_arith();
    setdp(8'h9C, 8'h75, 1'b0, 1'b1);
    run(8'h2B);
    run(8'h25, 8'h41);
    run(8'h26);
    run(8'h27);
    run(8'h24, 8'h8E);
    run(8'h3D);
    run(8'h34, 8'h8E);
    run(8'h9F);
    run(8'h94, 8'h8E);
    setdp(8'h7F, 8'h01, 1'b0, 1'b0);
    run(8'h28);
    run(8'h38);
    run(8'h98);
    $display("test arith done");
  endtask

  task automatic t_logic();
    setdp(8'hC3, 8'h5A, 1'b0, 1'b1);
    run(8'h52, 8'h3A);
    run(8'h53, 8'h3A, 8'h0F);
    run(8'h48);
    run(8'h4F);
    run(8'h62, 8'h3A);
    run(8'h63, 8'h3A, 8'hF0);
    $display("test logic done");
  endtask

  task automatic t_acc();
    for (int k = 0; k < 2; k++) begin
      setdp(8'hB4, 8'h00, 1'b0, k[0]);
      run(8'hC4);
      run(8'h33);
      run(8'h13);
    end
    $display("test accumulator done");
  endtask

  task automatic t_bits();
    logic [7:0] op [6] = '{8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92};
    for (int k = 0; k < 4; k++) begin
      setdp(8'h00, 8'h00, k[0], k[1]);
      foreach (op[i]) run(op[i], 8'h21);
    end
    $display("test boolean done");
  endtask

  task automatic t_stall();
    setdp(8'h9C, 8'h75, 1'b0, 1'b1);
    slow = 1'b1;
    run(8'h25, 8'h41);
    run(8'h53, 8'h3A, 8'h0F);
    run(8'h52, 8'h3A);
    slow = 1'b0;
    $display("test late bytes done");
  endtask

  task automatic t_b2b();
    int t [3];
    int k = 0;
    setdp(8'h12, 8'h34, 1'b0, 1'b0);
    @(posedge clk);
    pm.push(8'h28);
    pm.push(8'hC4);
    pm.push(8'h24);
    pm.push(8'h55);
    for (int n = 0; n < 20; n++) begin
      @(negedge clk);
      if (done === 1'b1 && k < 3) begin
        t[k] = cycCnt;
        k++;
      end
    end
    chk("b2bCount", 3, k);
    chk("gapSwap", 1, t[1] - t[0]);
    chk("gapImm", 2, t[2] - t[1]);
    chk("lastValue", 8'h67, resOut.value);
    $display("test back to back done");
  endtask

  task automatic t_illegal();
    setdp(8'h9C, 8'h75, 1'b1, 1'b1);
    run(8'h23);
    run(8'hC3);
    $display("test unknown opcode done");
  endtask

  // Reset in mid-instruction must drop it and leave the port usable
  task automatic t_midreset();
    @(posedge clk);
    pm.push(8'h53);
    pm.push(8'h3A);
    pm.push(8'h0F);
    repeat (2) @(negedge clk);
    chk("midBusyOn", 1'b1, busy);
    arst_n = 1'b0;
    @(negedge clk);
    chk("midBusy", 1'b0, busy);
    chk("midDone", 1'b0, done);
    chk("midReady", 1'b0, codeReady);
    arst_n = 1'b1;
    @(negedge clk);
    run(8'h2B);
    $display("test second reset done");
  endtask

  initial begin
    t_reset();
    t_arith();
    t_logic();
    t_acc();
    t_bits();
    t_stall();
    t_b2b();
    t_illegal();
    t_midreset();
    summarize();
  end

  // About 310 cycles expected; a hang trips this
  initial begin
    repeat (3000) @(posedge clk);
    errorCnt++;
    summarize();
  end
endmodule

`default_nettype wire
